/* hw/tgc_regs.svh */
// register offsets, field positions and reset values of the gate control block
`ifndef TGC_REGS_SVH
`define TGC_REGS_SVH
`define TGC_ADDR_GATE_CTRL  2'h0
`define TGC_ADDR_TIMER_CTRL 2'h1
`define TGC_ADDR_CNT_LOW    2'h2
`define TGC_ADDR_CNT_HIGH   2'h3
`define TGC_BIT_GATE_EN     7
`define TGC_BIT_GATE_POL    6
`define TGC_BIT_TOGGLE      5
`define TGC_BIT_SPM         4
`define TGC_BIT_ARM         3
`define TGC_BIT_GVAL        2
`define TGC_BIT_TIMER_ON    0
`define TGC_CTRL_RESET      8'h00
`define TGC_CNT_RESET       16'h0000
`define TGC_CNT_ONE         16'h0001
`define TGC_BYTE_RESET      8'h00
`define TGC_SYNC_RESET      3'h0
`define TGC_SRC_PIN         2'h0
`define TGC_SRC_MATCH       2'h1
`define TGC_SRC_CMP1        2'h2
`define TGC_SRC_CMP2        2'h3
`endif

/* hw/tgc_pkg.sv */
// types of the timer gate control block
package tgc_pkg;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tgc_bus_req_t;
    typedef struct packed {
        logic pin;
        logic match;
        logic cmp1;
        logic cmp2;
    } tgc_gate_src_t;
    typedef enum logic {
        TGC_SP_IDLE,
        TGC_SP_ARMED
    } tgc_sp_state_t;
endpackage

/* hw/tgc_gate_ctrl.sv */
// timer gate control with 16-bit counter and register port
`timescale 1ns/10ps
`include "tgc_regs.svh"
module tgc_gate_ctrl
    import tgc_pkg::*;
(
    input  wire logic          mclk_in,
    input  wire logic          rst_in,
    input  wire tgc_bus_req_t  bus_in,
    input  wire tgc_gate_src_t gate_src_in,
    input  wire logic          event_clr_in,
    output logic [7:0]         rdata_out,
    output logic               gate_event_flag_out,
    output logic               count_enable_out,
    output logic [15:0]        count_out
);
    logic [7:0]    gate_control_ff;
    logic [7:0]    timer_control_ff;
    logic [15:0]   count_ff;
    logic [7:0]    high_hold_ff;
    logic [7:0]    rdata_ff;
    logic [2:0]    sync_ff;
    logic          gate_prev_ff;
    logic          toggle_ff;
    logic          gval_ff;
    logic          gval_prev_ff;
    logic          flag_ff;
    tgc_sp_state_t sp_state_ff;
    logic          sp_window_ff;
    logic          raw_src;
    logic          gate_sync;
    logic          gate_rise;
    logic          pol_gate;
    logic          tog_gate;
    logic          nxt_gval;
    logic          gval_fall;
    logic          gate_done;
    logic          timer_on;
    logic          ctl_wr;
    logic          cnt_run;

    function automatic logic tgc_hit(input tgc_bus_req_t r, input logic [1:0] a);
        tgc_hit = r.wr && (r.addr == a);
    endfunction

    function automatic logic tgc_rd_hit(input tgc_bus_req_t r, input logic [1:0] a);
        tgc_rd_hit = r.rd && (r.addr == a);
    endfunction

    assign timer_on = timer_control_ff[`TGC_BIT_TIMER_ON];
    assign ctl_wr   = tgc_hit(bus_in, `TGC_ADDR_GATE_CTRL);

    // source select ahead of the synchroniser, so only one path needs it
    always_comb begin
        unique case (gate_control_ff[1:0])
            `TGC_SRC_PIN:   raw_src = gate_src_in.pin;
            `TGC_SRC_MATCH: raw_src = gate_src_in.match;
            `TGC_SRC_CMP1:  raw_src = gate_src_in.cmp1;
            `TGC_SRC_CMP2:  raw_src = gate_src_in.cmp2;
        endcase
    end

    // three stages; change accepted once stages two and three agree
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sync_ff      <= `TGC_SYNC_RESET;
            gate_prev_ff <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[1:0], raw_src};
            if (sync_ff[1] == sync_ff[2]) begin
                gate_prev_ff <= sync_ff[2];
            end
        end
    end
    assign gate_sync = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : gate_prev_ff;
    assign gate_rise = gate_sync && !gate_prev_ff;

    assign pol_gate = gate_control_ff[`TGC_BIT_GATE_POL] ? gate_sync : !gate_sync;

    // polarity applied before toggling so the measured edge follows polarity
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            toggle_ff <= 1'b0;
        end else if (!gate_control_ff[`TGC_BIT_TOGGLE] || !timer_on) begin
            toggle_ff <= 1'b0;
        end else if ((gate_control_ff[`TGC_BIT_GATE_POL] ? gate_rise
                     : (!gate_sync && gate_prev_ff)) && !gate_done) begin
            toggle_ff <= !toggle_ff;
        end
    end
    assign tog_gate = gate_control_ff[`TGC_BIT_TOGGLE] ? toggle_ff : pol_gate;

    // single pulse: window opens on the next active edge while armed
    assign gate_done = gate_control_ff[`TGC_BIT_SPM] && !gate_control_ff[`TGC_BIT_ARM]
                       && !sp_window_ff;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sp_state_ff  <= TGC_SP_IDLE;
            sp_window_ff <= 1'b0;
        end else if (!gate_control_ff[`TGC_BIT_SPM]) begin
            sp_state_ff  <= TGC_SP_IDLE;
            sp_window_ff <= 1'b0;
        end else begin
            unique case (sp_state_ff)
                TGC_SP_IDLE: begin
                    sp_window_ff <= 1'b0;
                    if (gate_control_ff[`TGC_BIT_ARM] && !tog_gate) begin
                        sp_state_ff <= TGC_SP_ARMED;
                    end
                end
                TGC_SP_ARMED: begin
                    if (tog_gate) begin
                        sp_window_ff <= 1'b1;
                    end else if (sp_window_ff) begin
                        sp_window_ff <= 1'b0;
                        sp_state_ff  <= TGC_SP_IDLE;
                    end
                end
            endcase
        end
    end

    assign nxt_gval = gate_control_ff[`TGC_BIT_SPM] ? (tog_gate && sp_window_ff) : tog_gate;
    assign gval_fall = gval_prev_ff && !gval_ff;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gval_ff      <= 1'b0;
            gval_prev_ff <= 1'b0;
        end else begin
            gval_ff      <= nxt_gval;
            gval_prev_ff <= gval_ff;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            flag_ff <= 1'b0;
        end else if (gval_fall) begin
            flag_ff <= 1'b1;
        end else if (event_clr_in) begin
            flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gate_control_ff <= `TGC_CTRL_RESET;
        end else begin
            if (ctl_wr) begin
                gate_control_ff[7:4] <= bus_in.wdata[7:4];
                gate_control_ff[1:0] <= bus_in.wdata[1:0];
            end
            if (ctl_wr && !bus_in.wdata[`TGC_BIT_SPM]) begin
                gate_control_ff[`TGC_BIT_ARM] <= 1'b0;
            end else if (sp_state_ff == TGC_SP_ARMED && sp_window_ff && !tog_gate) begin
                gate_control_ff[`TGC_BIT_ARM] <= 1'b0;
            end else if (ctl_wr) begin
                gate_control_ff[`TGC_BIT_ARM] <= bus_in.wdata[`TGC_BIT_ARM];
            end
            gate_control_ff[`TGC_BIT_GVAL] <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            timer_control_ff <= `TGC_CTRL_RESET;
        end else if (tgc_hit(bus_in, `TGC_ADDR_TIMER_CTRL)) begin
            timer_control_ff <= bus_in.wdata;
        end
    end

    assign cnt_run = timer_on && (!gate_control_ff[`TGC_BIT_GATE_EN] || gval_ff);

    // low write loads the high byte from the holding register and the low byte from the write data
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            count_ff     <= `TGC_CNT_RESET;
            high_hold_ff <= `TGC_BYTE_RESET;
        end else begin
            if (tgc_hit(bus_in, `TGC_ADDR_CNT_HIGH)) begin
                high_hold_ff <= bus_in.wdata;
            end else if (tgc_rd_hit(bus_in, `TGC_ADDR_CNT_LOW)) begin
                high_hold_ff <= count_ff[15:8];
            end
            if (tgc_hit(bus_in, `TGC_ADDR_CNT_LOW)) begin
                count_ff <= {high_hold_ff, bus_in.wdata};
            end else if (cnt_run) begin
                count_ff <= count_ff + `TGC_CNT_ONE;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_ff <= `TGC_BYTE_RESET;
        end else if (bus_in.rd) begin
            unique case (bus_in.addr)
                `TGC_ADDR_GATE_CTRL: rdata_ff <= {gate_control_ff[7:3], gval_ff,
                                                   gate_control_ff[1:0]};
                `TGC_ADDR_TIMER_CTRL: rdata_ff <= timer_control_ff;
                `TGC_ADDR_CNT_LOW:    rdata_ff <= count_ff[7:0];
                `TGC_ADDR_CNT_HIGH:   rdata_ff <= high_hold_ff;
            endcase
        end else begin
            rdata_ff <= `TGC_BYTE_RESET;
        end
    end

    assign rdata_out           = rdata_ff;
    assign gate_event_flag_out = flag_ff;
    assign count_enable_out    = cnt_run;
    assign count_out           = count_ff;

    a_timer_off_stops: assert property (@(posedge mclk_in) disable iff (rst_in)
        !timer_on && !tgc_hit(bus_in, `TGC_ADDR_CNT_LOW) |=> $stable(count_ff))
        else $error("counter moved while timer off");
    a_free_run: assert property (@(posedge mclk_in) disable iff (rst_in)
        timer_on && !gate_control_ff[`TGC_BIT_GATE_EN] |-> cnt_run)
        else $error("counter not free running");
    a_gated_count: assert property (@(posedge mclk_in) disable iff (rst_in)
        timer_on && gate_control_ff[`TGC_BIT_GATE_EN] && !gval_ff |-> !cnt_run)
        else $error("counter ran with gate inactive");
    a_toggle_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
        !gate_control_ff[`TGC_BIT_TOGGLE] |=> !toggle_ff)
        else $error("toggle flop not held clear");
    a_toggle_flip: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[`TGC_BIT_TOGGLE] && timer_on && gate_control_ff[`TGC_BIT_GATE_POL]
        && gate_rise && !gate_done |=> toggle_ff != $past(toggle_ff))
        else $error("toggle flop missed a rising edge");
    a_spm_clear_arm: assert property (@(posedge mclk_in) disable iff (rst_in)
        ctl_wr && !bus_in.wdata[`TGC_BIT_SPM] |=> !gate_control_ff[`TGC_BIT_ARM])
        else $error("arm bit survived mode clear");
    a_event_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
        gval_fall |=> flag_ff)
        else $error("gate event flag not set");
    a_gval_track: assert property (@(posedge mclk_in) disable iff (rst_in)
        !gate_control_ff[`TGC_BIT_SPM] |=> gval_ff == $past(tog_gate))
        else $error("gate value not tracking");
    a_spm_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[`TGC_BIT_SPM] && !gate_control_ff[`TGC_BIT_ARM] && !sp_window_ff
        |=> !gval_ff)
        else $error("gate passed while single pulse done");

    // the two steps of an armed acquisition
    sequence s_armed_waiting;
        gate_control_ff[`TGC_BIT_SPM] && sp_state_ff == TGC_SP_ARMED && !sp_window_ff
        && tog_gate;
    endsequence

    sequence s_trailing_edge;
        gate_control_ff[`TGC_BIT_SPM] && sp_state_ff == TGC_SP_ARMED && sp_window_ff
        && !tog_gate && !ctl_wr;
    endsequence

    a_window_open: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_armed_waiting |=> sp_window_ff)
        else $error("armed window did not open");

    a_arm_done: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_trailing_edge |=> !gate_control_ff[`TGC_BIT_ARM] && sp_state_ff == TGC_SP_IDLE)
        else $error("arm bit not cleared on trailing edge");

    a_idle_closed: assert property (@(posedge mclk_in) disable iff (rst_in)
        sp_state_ff == TGC_SP_IDLE |=> !sp_window_ff)
        else $error("window open while idle");

    a_spm_block: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[`TGC_BIT_SPM] && !sp_window_ff |=> !gval_ff)
        else $error("gate passed outside pulse window");

    a_spm_pass: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[`TGC_BIT_SPM] && sp_window_ff |=> gval_ff == $past(tog_gate))
        else $error("gate blocked inside pulse window");

    a_src_pin: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[1:0] == `TGC_SRC_PIN |-> raw_src == gate_src_in.pin)
        else $error("pin source not selected");

    a_src_match: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[1:0] == `TGC_SRC_MATCH |-> raw_src == gate_src_in.match)
        else $error("match source not selected");

    a_src_cmp1: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[1:0] == `TGC_SRC_CMP1 |-> raw_src == gate_src_in.cmp1)
        else $error("comparator one not selected");

    a_src_cmp2: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[1:0] == `TGC_SRC_CMP2 |-> raw_src == gate_src_in.cmp2)
        else $error("comparator two not selected");

    a_sync_agree: assert property (@(posedge mclk_in) disable iff (rst_in)
        sync_ff[1] == sync_ff[2] |=> gate_prev_ff == $past(sync_ff[2]))
        else $error("agreed level not accepted");

    a_sync_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
        sync_ff[1] != sync_ff[2] |-> gate_sync == gate_prev_ff)
        else $error("unsettled level passed through");

    a_timer_off_toggle: assert property (@(posedge mclk_in) disable iff (rst_in)
        !timer_on |=> !toggle_ff)
        else $error("toggle flop not cleared with timer off");

    a_toggle_flip_low: assert property (@(posedge mclk_in) disable iff (rst_in)
        gate_control_ff[`TGC_BIT_TOGGLE] && timer_on && !gate_control_ff[`TGC_BIT_GATE_POL]
        && !gate_sync && gate_prev_ff && !gate_done |=> toggle_ff != $past(toggle_ff))
        else $error("toggle flop missed an active low edge");

    a_gval_readback: assert property (@(posedge mclk_in) disable iff (rst_in)
        tgc_rd_hit(bus_in, `TGC_ADDR_GATE_CTRL) |=> rdata_ff[`TGC_BIT_GVAL] == $past(gval_ff))
        else $error("gate value not read back");

    a_high_latch: assert property (@(posedge mclk_in) disable iff (rst_in)
        tgc_rd_hit(bus_in, `TGC_ADDR_CNT_LOW) && !tgc_hit(bus_in, `TGC_ADDR_CNT_HIGH)
        |=> high_hold_ff == $past(count_ff[15:8]))
        else $error("high byte not latched on low read");

    a_low_load: assert property (@(posedge mclk_in) disable iff (rst_in)
        tgc_hit(bus_in, `TGC_ADDR_CNT_LOW) |=> count_ff == {$past(high_hold_ff), $past(bus_in.wdata)})
        else $error("counter not loaded from both bytes");

    a_count_step: assert property (@(posedge mclk_in) disable iff (rst_in)
        cnt_run && !tgc_hit(bus_in, `TGC_ADDR_CNT_LOW) |=> count_ff == $past(count_ff) + `TGC_CNT_ONE)
        else $error("counter did not step");

    a_count_gated: assert property (@(posedge mclk_in) disable iff (rst_in)
        timer_on && gate_control_ff[`TGC_BIT_GATE_EN] && !gval_ff
        && !tgc_hit(bus_in, `TGC_ADDR_CNT_LOW) |=> $stable(count_ff))
        else $error("counter moved with gate closed");

    a_flag_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
        flag_ff && !event_clr_in |=> flag_ff)
        else $error("gate event flag dropped without clear");
endmodule

/* tb/test_timer_gate_control.sv */
// self-checking bench for the timer gate control block
`timescale 1ns/10ps
`include "tgc_regs.svh"
module test_timer_gate_control
    import tgc_pkg::*;
;
    logic          mclk_in = 1'b0;
    logic          rst_in = 1'b1;
    tgc_bus_req_t  bus = '0;
    tgc_gate_src_t src = '0;
    logic          ev_clr = 1'b0;
    logic [7:0]    rdata;
    logic          flag;
    logic          cen;
    logic [15:0]   cnt;
    logic [7:0]    rv;
    int            failures = 0;
    int            n_compared = 0;

    always #20 mclk_in = ~mclk_in;

    tgc_gate_ctrl u_dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .bus_in(bus), .gate_src_in(src),
        .event_clr_in(ev_clr), .rdata_out(rdata), .gate_event_flag_out(flag),
        .count_enable_out(cen), .count_out(cnt));

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [1:0] a);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in);
        bus.rd <= 1'b0;
        #1 rv = rdata;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask

    // gate path has a synchroniser, so poll under a bound
    task automatic wait_en(input logic exp);
        for (int i = 0; i < 20 && cen !== exp; i++)
            cycles(1);
        check("count_enable", {15'h0000, cen}, {15'h0000, exp});
        if (cen !== exp)
            tally_and_finish();
    endtask

    task automatic pin_to(input logic v);
        @(posedge mclk_in);
        src.pin <= v;
        cycles(8);
    endtask

    task automatic pulse;
        pin_to(1'b1);
        pin_to(1'b0);
    endtask

    task automatic t_reset;
        rd(`TGC_ADDR_GATE_CTRL);
        check("gate_control", rv & 8'hfb, 8'h00);
        rd(`TGC_ADDR_TIMER_CTRL);
        check("timer_control", rv, 8'h00);
        check("count", cnt, `TGC_CNT_RESET);
    endtask

    task automatic t_counter;
        logic [15:0] c0;
        wr(`TGC_ADDR_CNT_HIGH, 8'ha5);
        wr(`TGC_ADDR_CNT_LOW, 8'h3c);
        check("count", cnt, 16'ha53c);
        rd(`TGC_ADDR_CNT_LOW);
        check("low byte", rv, 8'h3c);
        rd(`TGC_ADDR_CNT_HIGH);
        check("high byte", rv, 8'ha5);
        wr(`TGC_ADDR_TIMER_CTRL, 8'h01);
        c0 = cnt;
        cycles(10);
        check("free count", cnt, c0 + 16'h000a);
        wr(`TGC_ADDR_TIMER_CTRL, 8'h00);
        c0 = cnt;
        cycles(5);
        check("stopped count", cnt, c0);
    endtask

    task automatic t_sources;
        for (int s = 0; s < 4; s++) begin
            wr(`TGC_ADDR_GATE_CTRL, 8'h40 | 8'(s));
            @(posedge mclk_in);
            src <= tgc_gate_src_t'(4'b1000 >> s);
            cycles(8);
            rd(`TGC_ADDR_GATE_CTRL);
            check("gate value high", rv[2], 1'b1);
            @(posedge mclk_in);
            src <= tgc_gate_src_t'(~(4'b1000 >> s));
            cycles(8);
            rd(`TGC_ADDR_GATE_CTRL);
            check("gate value low", rv[2], 1'b0);
        end
    endtask

    task automatic t_flag;
        @(posedge mclk_in);
        ev_clr <= 1'b1;
        @(posedge mclk_in);
        ev_clr <= 1'b0;
        @(posedge mclk_in);
        src.cmp2 <= 1'b1;
        cycles(8);
        check("flag after rise", flag, 1'b0);
        @(posedge mclk_in);
        src.cmp2 <= 1'b0;
        cycles(8);
        check("flag after fall", flag, 1'b1);
    endtask

    task automatic t_polarity;
        wr(`TGC_ADDR_TIMER_CTRL, 8'h01);
        wr(`TGC_ADDR_GATE_CTRL, 8'hc0);
        pin_to(1'b0);
        wait_en(1'b0);
        pin_to(1'b1);
        wait_en(1'b1);
        wr(`TGC_ADDR_GATE_CTRL, 8'h80);
        wait_en(1'b0);
        pin_to(1'b0);
        wait_en(1'b1);
    endtask

    task automatic t_toggle;
        wr(`TGC_ADDR_GATE_CTRL, 8'he0);
        wait_en(1'b0);
        pulse();
        wait_en(1'b1);
        pulse();
        wait_en(1'b0);
        pulse();
        wr(`TGC_ADDR_TIMER_CTRL, 8'h00);
        wr(`TGC_ADDR_TIMER_CTRL, 8'h01);
        wait_en(1'b0);
        pulse();
        wr(`TGC_ADDR_GATE_CTRL, 8'hc0);
        wr(`TGC_ADDR_GATE_CTRL, 8'he0);
        wait_en(1'b0);
    endtask

    task automatic t_pulse;
        wr(`TGC_ADDR_GATE_CTRL, 8'hd0);
        wr(`TGC_ADDR_GATE_CTRL, 8'hd8);
        rd(`TGC_ADDR_GATE_CTRL);
        check("armed", rv[3], 1'b1);
        pin_to(1'b1);
        wait_en(1'b1);
        pin_to(1'b0);
        wait_en(1'b0);
        rd(`TGC_ADDR_GATE_CTRL);
        check("done", rv[3], 1'b0);
        pin_to(1'b1);
        check("ignored pulse", cen, 1'b0);
        pin_to(1'b0);
        wr(`TGC_ADDR_GATE_CTRL, 8'hd8);
        wr(`TGC_ADDR_GATE_CTRL, 8'hc8);
        rd(`TGC_ADDR_GATE_CTRL);
        check("arm cleared", rv[3], 1'b0);
        wr(`TGC_ADDR_GATE_CTRL, 8'hf0);
        wr(`TGC_ADDR_GATE_CTRL, 8'hf8);
        pulse();
        wait_en(1'b1);
        pulse();
        wait_en(1'b0);
        rd(`TGC_ADDR_GATE_CTRL);
        check("period done", rv[3], 1'b0);
    endtask

    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_counter();
        t_sources();
        t_flag();
        t_polarity();
        t_toggle();
        t_pulse();
        tally_and_finish();
    end
endmodule
